/* hdl/ebra_params.svh */
// Constants of the external bus engine: widths, reset levels and counts.
// Assumes inclusion by the package, the top module and the verification files.
`ifndef EBRA_PARAMS_SVH
`define EBRA_PARAMS_SVH
// Address, data and phase counter widths.
`define EBRA_AW 24
`define EBRA_DW 16
`define EBRA_WW 4
// Least waitstate count when the termination input is synchronised.
`define EBRA_ASYNC_MIN_WAIT 4'h1
// Inactive level of the read and write strobes.
`define EBRA_CMD_IDLE 1'b1
// Reset values of the held words and of the phase counter.
`define EBRA_ADDR_RST 24'h000000
`define EBRA_DATA_RST 16'h0000
`define EBRA_WAIT_RST 4'h0
// Width of the bundles that cross into each domain.
`define EBRA_L_SYNC_W 13
`define EBRA_C_SYNC_W 2
`endif

/* hdl/ebra_pkg.sv */
// Types of the external bus engine: states and the per-module state records.
// Assumes ebra_params.svh is on the include path.
`include "ebra_params.svh"
package ebra_pkg;
    // Bus cycle sequencer states on the link clock.
    typedef enum logic [1:0] {EBRA_L_IDLE, EBRA_L_ADDR, EBRA_L_CMD} ebra_link_st_t;
    // Arbitration states on the link clock.
    typedef enum logic [2:0] {
        EBRA_A_OWN, EBRA_A_INACT, EBRA_A_FLOAT, EBRA_A_GRANT, EBRA_A_REGAIN, EBRA_A_DRIVE
    } ebra_arb_st_t;
    // Arbiter record: state plus registered outputs.
    typedef struct packed {
        ebra_arb_st_t st;
        logic owned;
        logic ctl_oe;
        logic grant;
        logic regain;
    } ebra_arb_t;
    // System clock side record.
    typedef struct packed {
        logic req_tgl;
        logic ack_seen;
        logic busy;
        logic done;
        logic granted;
        logic write;
        logic [`EBRA_AW-1:0] addr;
        logic [`EBRA_DW-1:0] wdata;
        logic [`EBRA_DW-1:0] rdata;
    } ebra_clk_t;
    // Link clock side record; pin fields feed the top outputs directly.
    typedef struct packed {
        ebra_link_st_t st;
        logic [`EBRA_WW-1:0] cnt;
        logic req_seen;
        logic ack_tgl;
        logic write;
        logic [`EBRA_DW-1:0] rdata;
        logic rd_n;
        logic wr_n;
        logic ale;
        logic [`EBRA_AW-1:0] addr;
        logic [`EBRA_DW-1:0] dout;
        logic data_oe;
        logic ctl_oe;
        logic grant_n;
        logic bus_regain_request_n;
        logic ref_clk;
    } ebra_link_t;
endpackage

/* hdl/ebra_arb_if.sv */
// Signals between the bus sequencer and the arbiter, both on the link clock.
// Assumes both ends sit in the same clock domain.
interface ebra_arb_if;
    logic hold_req;     // Hold request, synchronised, active high.
    logic arb_en;       // Arbitration enabled.
    logic cycle_active; // Sequencer is inside a bus cycle.
    logic own_need;     // Device wants its bus back.
    logic owned;        // Device owns the bus and may start cycles.
    logic ctl_oe;       // Control and address pins are driven.
    logic grant;        // Bus granted to the other master.
    logic regain;       // Bus regain request.
    modport ctl (output hold_req, arb_en, cycle_active, own_need,
                 input owned, ctl_oe, grant, regain);
    modport arb (input hold_req, arb_en, cycle_active, own_need,
                 output owned, ctl_oe, grant, regain);
endinterface

/* hdl/ebra_sync.sv */
// Two flip-flop synchroniser for a bundle of levels.
// Assumes each bit is a level or a toggle that holds for several clocks.
module ebra_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // Both stages in one record; the first stage feeds only the second.
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ebra_sync_t;
    ebra_sync_t r;
    ebra_sync_t next_r;
    // No reset here: the reset itself crosses through this module.
    always_comb begin
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end
    always_ff @(posedge clk) begin
        r <= next_r;
    end
    assign q = r.s2;
endmodule

/* hdl/ebra_arb.sv */
// Bus release and regain sequencer for the external hold handshake.
// Assumes the hold request is already synchronised to this clock.
module ebra_arb
    import ebra_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    ebra_arb_if.arb a
);
    ebra_arb_t r;
    ebra_arb_t next_r;
    // Walks own, drive inactive, float, grant, release grant, drive, own.
    always_comb begin
        next_r = r;
        case (r.st)
            EBRA_A_OWN: begin
                // Only a finished cycle is given away.
                if (a.arb_en && a.hold_req && !a.cycle_active) begin
                    next_r.st = EBRA_A_INACT;
                end
            end
            EBRA_A_INACT: next_r.st = EBRA_A_FLOAT; // Driven inactive first.
            EBRA_A_FLOAT: next_r.st = EBRA_A_GRANT; // Pull-ups take over.
            EBRA_A_GRANT: begin
                // Hold going away starts the regain, asked for or not.
                if (!a.hold_req) begin
                    next_r.st = EBRA_A_REGAIN;
                end
            end
            EBRA_A_REGAIN: next_r.st = EBRA_A_DRIVE;
            EBRA_A_DRIVE: next_r.st = EBRA_A_OWN; // Inactive before own cycle.
            default: next_r.st = EBRA_A_OWN;
        endcase
        next_r.owned = (next_r.st == EBRA_A_OWN);
        next_r.ctl_oe = (next_r.st == EBRA_A_OWN) || (next_r.st == EBRA_A_INACT)
                     || (next_r.st == EBRA_A_DRIVE);
        // Grant only once floating, dropped at regain start.
        next_r.grant = (next_r.st == EBRA_A_GRANT);
        // Regain request only while granted.
        next_r.regain = (next_r.st == EBRA_A_GRANT) && a.own_need;
        if (rst) begin
            next_r = '{st: EBRA_A_OWN, owned: 1'b1, ctl_oe: 1'b1, grant: 1'b0, regain: 1'b0};
        end
    end
    always_ff @(posedge clk) begin
        r <= next_r;
    end
    assign a.owned = r.owned;
    assign a.ctl_oe = r.ctl_oe;
    assign a.grant = r.grant;
    assign a.regain = r.regain;
endmodule

/* hdl/ebra_top.sv */
// External bus engine: ready-terminated cycles, read capture, hold arbitration.
// Assumes the request side runs on CLK and the pins on LINK_CLK, which runs
// whenever RST is applied; configuration inputs change only while idle.
//
// Notes on behaviour
// - Ready active level selectable.
// - Synchronous ready sampled directly, no synchroniser.
// - Asynchronous ready synchronised, costs one waitstate minimum.
// - First sample point follows programmed phases.
// - Inactive ready inserts waitstate, resample.
// - Active ready ends the running cycle.
// - Asynchronous sample point later than synchronous.
// - Read data latched with strobe rise.
// - Early address change ignored for capture.
// - Release bus only when arbitration enabled.
// - Finish running cycle before granting.
// - Release: drive inactive, then float, ALE low.
// - Hold going high starts regain sequence.
// - Hold may drop unrequested; regain normally.
// - Regain: drive controls inactive before own cycle.
// - Regain request only after release and grant.
`include "ebra_params.svh"
module ebra_top
    import ebra_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic LINK_CLK,
    input wire logic CFG_READY_POL,
    input wire logic CFG_READY_EN,
    input wire logic CFG_READY_ASYNC,
    input wire logic CFG_ARB_EN,
    input wire logic [`EBRA_WW-1:0] CFG_WAIT,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [`EBRA_AW-1:0] REQ_ADDR,
    input wire logic [`EBRA_DW-1:0] REQ_WDATA,
    input wire logic BUS_NEED,
    output logic REQ_BUSY,
    output logic REQ_DONE,
    output logic [`EBRA_DW-1:0] RD_DATA,
    output logic BUS_GRANTED,
    input wire logic READY_PIN,
    input wire logic HOLD_N,
    output logic HOLD_GRANT_N,
    output logic BUS_REGAIN_REQ_N,
    output logic BUS_REF_CLK,
    output logic RD_N_O,
    output logic RD_N_OE,
    output logic WR_N_O,
    output logic WR_N_OE,
    output logic ALE_O,
    output logic ALE_OE,
    output logic [`EBRA_AW-1:0] ADDR_O,
    output logic ADDR_OE,
    input wire logic [`EBRA_DW-1:0] DATA_I,
    output logic [`EBRA_DW-1:0] DATA_O,
    output logic DATA_OE
);

    ////////////////////////////////////////////////////////////////////////////
    // Domain crossings.

    ebra_clk_t c;       // Request side record.
    ebra_clk_t next_c;  // Its next value.
    ebra_link_t l;      // Link side record.
    ebra_link_t next_l; // Its next value.

    logic [`EBRA_L_SYNC_W-1:0] ls_q; // Bundle seen on the link clock.
    logic [`EBRA_C_SYNC_W-1:0] cs_q; // Bundle seen on the system clock.

    // Reset, pins, the request toggle and configuration levels all cross
    // into the link domain together; each bit is a level or a slow toggle.
    ebra_sync #(.W(`EBRA_L_SYNC_W)) u_lsync (
        .clk(LINK_CLK),
        .d({BUS_NEED, RST, HOLD_N, READY_PIN, c.req_tgl, CFG_READY_POL, CFG_READY_EN,
            CFG_READY_ASYNC, CFG_ARB_EN, CFG_WAIT}),
        .q(ls_q)
    );

    // The acknowledge toggle and the grant level cross back.
    ebra_sync #(.W(`EBRA_C_SYNC_W)) u_csync (
        .clk(CLK),
        .d({l.ack_tgl, ~l.grant_n}),
        .q(cs_q)
    );

    logic lrst;                    // Reset seen on the link clock.
    logic hold_s;                  // Hold request, active high.
    logic rdy_async;               // Synchronised ready pin.
    logic req_s;                   // Request toggle.
    logic pol_s;                   // Ready active level.
    logic rdy_en_s;                // Ready control enabled.
    logic async_s;                 // Asynchronous ready mode.
    logic arb_en_s;                // Arbitration enabled.
    logic [`EBRA_WW-1:0] wait_s;   // Programmed waitstates.
    logic ack_s;                   // Acknowledge toggle on CLK.
    logic grant_s;                 // Grant level on CLK.

    assign lrst = ls_q[11];
    assign hold_s = ~ls_q[10];
    assign rdy_async = ls_q[9];
    assign req_s = ls_q[8];
    assign pol_s = ls_q[7];
    assign rdy_en_s = ls_q[6];
    assign async_s = ls_q[5];
    assign arb_en_s = ls_q[4];
    assign wait_s = ls_q[3:0];
    assign ack_s = cs_q[1];
    assign grant_s = cs_q[0];

    ////////////////////////////////////////////////////////////////////////////
    // Request side on the system clock.

    // One request at a time: the words are held in the record until the
    // acknowledge returns, so the link side may read them without hazard.
    always_comb begin
        next_c = c;
        next_c.done = 1'b0;
        next_c.granted = grant_s;
        // A new request is taken only while no cycle is outstanding.
        if (REQ_VALID && !c.busy) begin
            next_c.busy = 1'b1;
            next_c.req_tgl = ~c.req_tgl;
            next_c.write = REQ_WRITE;
            next_c.addr = REQ_ADDR;
            next_c.wdata = REQ_WDATA;
        end
        // The link's read data are stable once the toggle has crossed.
        if (ack_s != c.ack_seen) begin
            next_c.ack_seen = ack_s;
            next_c.busy = 1'b0;
            next_c.done = 1'b1;
            next_c.rdata = l.rdata;
        end
        if (RST) begin
            next_c.req_tgl = 1'b0;
            next_c.ack_seen = 1'b0;
            next_c.busy = 1'b0;
            next_c.done = 1'b0;
            next_c.granted = 1'b0;
            next_c.write = 1'b0;
            next_c.addr = `EBRA_ADDR_RST;
            next_c.wdata = `EBRA_DATA_RST;
            next_c.rdata = `EBRA_DATA_RST;
        end
    end

    // The acknowledge seen flag follows the link's reset value of zero;
    // the link is held in reset while RST is high, so both start aligned.
    always_ff @(posedge CLK) begin
        c <= next_c;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration on the link clock.

    ebra_arb_if ai ();

    assign ai.hold_req = hold_s;
    assign ai.arb_en = arb_en_s;
    assign ai.cycle_active = (l.st != EBRA_L_IDLE);
    assign ai.own_need = ls_q[12];

    ebra_arb u_arb (
        .clk(LINK_CLK),
        .rst(lrst),
        .a(ai.arb)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer on the link clock.

    logic rdy_raw;  // Ready pin at this edge, taken straight from the pad.
    logic rdy_seen; // Ready judged active at this sample point.
    logic [`EBRA_WW-1:0] first_wait; // Waitstates before the first sample.

    // Synchronous mode reads the pad directly for the shortest cycle, so
    // the outside must drive it in step with the reference clock.
    assign rdy_raw = READY_PIN;

    always_comb begin
        // Either level may mean ready.
        // Asynchronous mode looks at the synchroniser output, which moves
        // the effective sample point two link edges later.
        if (async_s) begin
            rdy_seen = (rdy_async == pol_s);
        end else begin
            rdy_seen = (rdy_raw == pol_s);
        end
        // The programmed phases set the first sample point; asynchronous
        // mode never has fewer than one waitstate.
        if (async_s && (wait_s < `EBRA_ASYNC_MIN_WAIT)) begin
            first_wait = `EBRA_ASYNC_MIN_WAIT;
        end else begin
            first_wait = wait_s;
        end
    end

    // Address phase with ALE, then command phase with programmed waits,
    // then ready sampling; the ending edge raises the strobe and latches.
    always_comb begin
        next_l = l;
        next_l.ref_clk = ~l.ref_clk;
        case (l.st)
            EBRA_L_IDLE: begin
                // Start only while owning the bus and no honoured hold is pending,
                // so the arbiter never sees a cycle begin under it.
                if ((req_s != l.req_seen) && ai.owned && !(hold_s && arb_en_s)) begin
                    next_l.req_seen = req_s;
                    next_l.st = EBRA_L_ADDR;
                    next_l.write = c.write;
                    next_l.addr = c.addr;
                    next_l.dout = c.wdata;
                    next_l.ale = 1'b1;
                end
            end
            EBRA_L_ADDR: begin
                // Strobe goes active; write data appear with it.
                next_l.ale = 1'b0;
                next_l.st = EBRA_L_CMD;
                next_l.cnt = first_wait;
                if (l.write) begin
                    next_l.wr_n = ~`EBRA_CMD_IDLE;
                    next_l.data_oe = 1'b1;
                end else begin
                    next_l.rd_n = ~`EBRA_CMD_IDLE;
                end
            end
            EBRA_L_CMD: begin
                if (l.cnt != `EBRA_WAIT_RST) begin
                    // Mandatory phase waitstates pass before sampling.
                    next_l.cnt = l.cnt - 4'h1;
                end else if (!rdy_en_s || rdy_seen) begin
                    // Ready active ends the cycle.
                    // The data bus is latched on the very edge that
                    // raises the strobe; the address does not take part,
                    // so an early address change has no effect.
                    if (!l.write) begin
                        next_l.rdata = DATA_I;
                    end
                    next_l.rd_n = `EBRA_CMD_IDLE;
                    next_l.wr_n = `EBRA_CMD_IDLE;
                    next_l.data_oe = 1'b0;
                    next_l.ack_tgl = ~l.ack_tgl;
                    next_l.st = EBRA_L_IDLE;
                end
                // Otherwise one ready waitstate, sampled again next edge.
                // The outside may drop ready after the strobe rises, and
                // must have it inactive by the next first sample.
            end
            default: next_l.st = EBRA_L_IDLE;
        endcase
        // Pin enables and the hold handshake follow the arbiter; while it
        // floats the pins, ALE stays driven low.
        next_l.ctl_oe = ai.ctl_oe;
        next_l.grant_n = ~ai.grant;
        next_l.bus_regain_request_n = ~ai.regain;
        if (lrst) begin
            next_l.st = EBRA_L_IDLE;
            next_l.cnt = `EBRA_WAIT_RST;
            next_l.req_seen = 1'b0;
            next_l.ack_tgl = 1'b0;
            next_l.write = 1'b0;
            next_l.rdata = `EBRA_DATA_RST;
            next_l.rd_n = `EBRA_CMD_IDLE;
            next_l.wr_n = `EBRA_CMD_IDLE;
            next_l.ale = 1'b0;
            next_l.addr = `EBRA_ADDR_RST;
            next_l.dout = `EBRA_DATA_RST;
            next_l.data_oe = 1'b0;
            next_l.ctl_oe = 1'b1;
            next_l.grant_n = 1'b1;
            next_l.bus_regain_request_n = 1'b1;
            next_l.ref_clk = 1'b0;
        end
    end

    // The reference clock output is a registered half-rate copy of the
    // link clock, so synchronous ready logic outside has a clean edge.
    always_ff @(posedge LINK_CLK) begin
        l <= next_l;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a register except ALE_OE, tied high.

    assign REQ_BUSY = c.busy;
    assign REQ_DONE = c.done;
    assign RD_DATA = c.rdata;
    assign BUS_GRANTED = c.granted;
    assign HOLD_GRANT_N = l.grant_n;
    assign BUS_REGAIN_REQ_N = l.bus_regain_request_n;
    assign BUS_REF_CLK = l.ref_clk;
    assign RD_N_O = l.rd_n;
    assign RD_N_OE = l.ctl_oe;
    assign WR_N_O = l.wr_n;
    assign WR_N_OE = l.ctl_oe;
    assign ALE_O = l.ale;
    // ALE is never floated, which keeps external latches closed in hold.
    assign ALE_OE = 1'b1;
    assign ADDR_O = l.addr;
    assign ADDR_OE = l.ctl_oe;
    assign DATA_O = l.dout;
    assign DATA_OE = l.data_oe;

endmodule

/* verif/ebra_properties.sv */
// Pin checker of the external bus engine, link clock domain only.
// Assumes a bind into ebra_top and configuration held steady around cycles.
`include "ebra_params.svh"
module ebra_properties (
    input wire logic LINK_CLK,
    input wire logic RST,
    input wire logic CFG_READY_POL,
    input wire logic CFG_READY_EN,
    input wire logic CFG_READY_ASYNC,
    input wire logic CFG_ARB_EN,
    input wire logic [`EBRA_WW-1:0] CFG_WAIT,
    input wire logic READY_PIN,
    input wire logic HOLD_N,
    input wire logic HOLD_GRANT_N,
    input wire logic BUS_REGAIN_REQ_N,
    input wire logic RD_N_O,
    input wire logic RD_N_OE,
    input wire logic WR_N_O,
    input wire logic WR_N_OE,
    input wire logic ALE_O,
    input wire logic ADDR_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    // Every check runs on the link clock and rests while reset is applied.
    default clocking cb @(posedge LINK_CLK);
    endclocking
    default disable iff (RST);
    // A command strobe is low while a cycle runs.
    logic strobe;
    // Synchronous ready with no mandatory wait samples on every strobe-low edge.
    logic sync0;
    assign strobe = !(RD_N_O && WR_N_O);
    assign sync0 = CFG_READY_EN && !CFG_READY_ASYNC && CFG_WAIT == 4'h0 && strobe;
    ////////////////////////////////////////////////////////////////////////////
    property p_sync_end;
        sync0 && READY_PIN == CFG_READY_POL |=> !strobe;
    endproperty
    a_sync_end: assert property (p_sync_end) else $error("ready did not end cycle");
    property p_sync_wait;
        sync0 && READY_PIN != CFG_READY_POL |=> strobe;
    endproperty
    a_sync_wait: assert property (p_sync_wait) else $error("cycle ended unready");
    // The synchroniser costs at least one wait, so the strobe stays low.
    property p_async_min;
        $fell(RD_N_O) && CFG_READY_ASYNC && CFG_READY_EN |=> !RD_N_O;
    endproperty
    a_async_min: assert property (p_async_min) else $error("async cycle too short");
    property p_release;
        $fell(ADDR_OE) |-> $past(RD_N_O) && $past(WR_N_O) && !ALE_O
            && $past(HOLD_N, 3) == 1'h0 && $past(CFG_ARB_EN, 3);
    endproperty
    a_release: assert property (p_release) else $error("bad bus release");
    property p_grant;
        $fell(HOLD_GRANT_N) |-> !RD_N_OE && !WR_N_OE && !ADDR_OE;
    endproperty
    a_grant: assert property (p_grant) else $error("grant before float");
    property p_regain_req;
        !BUS_REGAIN_REQ_N |-> !HOLD_GRANT_N && !ADDR_OE;
    endproperty
    a_regain_req: assert property (p_regain_req) else $error("early regain request");
    property p_drive;
        $rose(ADDR_OE) |-> RD_N_O && WR_N_O && !ALE_O && HOLD_GRANT_N;
    endproperty
    a_drive: assert property (p_drive) else $error("bad bus regain");
    property p_grant_end;
        $rose(HOLD_GRANT_N) |-> $past(HOLD_N, 2);
    endproperty
    a_grant_end: assert property (p_grant_end) else $error("grant dropped early");
endmodule
bind ebra_top ebra_properties ebra_properties_inst (.LINK_CLK, .RST, .CFG_READY_POL,
    .CFG_READY_EN, .CFG_READY_ASYNC, .CFG_ARB_EN, .CFG_WAIT, .READY_PIN, .HOLD_N,
    .HOLD_GRANT_N, .BUS_REGAIN_REQ_N, .RD_N_O, .RD_N_OE, .WR_N_O, .WR_N_OE, .ALE_O, .ADDR_OE);

/* verif/ebra_mem_model.sv */
// Memory at the far end of the bus; it ends each command with the ready input.
// Assumes strobes already resolved against their pull-ups by the bench.
`include "ebra_params.svh"
module ebra_mem_model (
    input wire logic lclk,
    input wire logic pol,
    input wire logic [3:0] delay,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [`EBRA_AW-1:0] addr,
    input wire logic [`EBRA_DW-1:0] dout,
    output logic ready,
    output logic [`EBRA_DW-1:0] din
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sixteen words, picked by the low address bits.
    logic [`EBRA_DW-1:0] mem [16] = '{default: 16'h0000};
    // Shown when not read; it changes every cycle so stale data cannot pass.
    logic [`EBRA_DW-1:0] junk = 16'hA5C3;
    // Cycles the strobe has been low.
    logic [3:0] cnt = 4'h0;
    initial ready = 1'h0;
    // Ready changes just after the link clock that the reference clock follows.
    always @(posedge lclk) begin
        junk <= ~junk;
        if (rd_n && wr_n) begin
            cnt <= 4'h0;
            ready <= ~pol; // Withdrawn once the strobe rises, before a later sample.
        end else begin
            cnt <= cnt + 4'h1;
            ready <= (cnt >= delay) ? pol : ~pol; // Held until the strobe ends.
        end
        if (!wr_n) begin
            mem[addr[3:0]] <= dout;
        end
    end
    // Read data stand only while the read strobe is low.
    assign din = rd_n ? junk : mem[addr[3:0]];
endmodule

/* verif/ebra_top_tb_top.sv */
// Self-checking bench of the external bus engine: cycles, ready modes, hold.
// Assumes the design, the checker and the memory model are compiled first.
`include "ebra_params.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module ebra_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, lclk = 1'h0, rst = 1'h1, pol = 1'h1, en = 1'h1, asy = 1'h0;
    logic arb = 1'h0, need = 1'h0, valid = 1'h0, wr = 1'h0, hold_n = 1'h1;
    logic [3:0] wt = 4'h0, dly = 4'h0;
    logic [`EBRA_AW-1:0] addr = 24'h000000, a_o;
    logic [`EBRA_DW-1:0] wdata = 16'h0000, rdata, din, dout;
    logic busy, done, granted, ready, hg_n, br_n, rd_n, rd_oe, wr_n, wr_oe, ale, a_oe, doe;
    // Shadow of the memory; modes hold {polarity, ready enable, async}.
    logic [`EBRA_DW-1:0] shadow [16] = '{default: 16'h0000};
    logic [2:0] modes [5] = '{3'h6, 3'h2, 3'h7, 3'h3, 3'h4};
    int fails = 0;
    int total_checks = 0;
    // Released strobes float to their pull-ups.
    wire rd_w = rd_oe ? rd_n : 1'h1;
    wire wr_w = wr_oe ? wr_n : 1'h1;
    ebra_top ebra_top_inst (.CLK(clk), .RST(rst), .LINK_CLK(lclk), .CFG_READY_POL(pol),
        .CFG_READY_EN(en), .CFG_READY_ASYNC(asy), .CFG_ARB_EN(arb), .CFG_WAIT(wt),
        .REQ_VALID(valid), .REQ_WRITE(wr), .REQ_ADDR(addr), .REQ_WDATA(wdata),
        .BUS_NEED(need), .REQ_BUSY(busy), .REQ_DONE(done), .RD_DATA(rdata),
        .BUS_GRANTED(granted), .READY_PIN(ready), .HOLD_N(hold_n), .HOLD_GRANT_N(hg_n),
        .BUS_REGAIN_REQ_N(br_n), .BUS_REF_CLK(), .RD_N_O(rd_n), .RD_N_OE(rd_oe),
        .WR_N_O(wr_n), .WR_N_OE(wr_oe), .ALE_O(ale), .ALE_OE(), .ADDR_O(a_o),
        .ADDR_OE(a_oe), .DATA_I(din), .DATA_O(dout), .DATA_OE(doe));
    ebra_mem_model ebra_mem_model_inst (.lclk(lclk), .pol(pol), .delay(dly), .rd_n(rd_w),
        .wr_n(wr_w), .addr(a_o), .dout(dout), .ready(ready), .din(din));
    always #5 clk = ~clk;
    always #16 lclk = ~lclk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("Checks %0d, errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    function automatic logic [15:0] exp_rd(input logic [23:0] a);
        return shadow[a[3:0]];
    endfunction
    function automatic logic seen(input int sel);
        case (sel)
            0: return done === 1'h1;
            1: return rd_n === 1'h0;
            2: return granted === 1'h1;
            default: return granted === 1'h0;
        endcase
    endfunction
    // Bounded wait; running out counts as a mismatch and ends the run.
    task automatic wait_on(input int sel);
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk);
            if (seen(sel)) return;
        end
        fails++;
        $display("Error wait %0d expected 1 seen 0", sel);
        tally_and_finish();
    endtask
    // Configuration changes only while idle, then gets time to cross.
    task automatic cfg(input int m, input logic [3:0] w, input logic [3:0] d);
        @(posedge clk);
        {pol, en, asy} <= modes[m];
        wt <= w;
        dly <= d;
        repeat (12) @(posedge clk);
    endtask
    task automatic issue(input logic w, input logic [23:0] a, input logic [15:0] d);
        @(posedge clk);
        valid <= 1'h1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        valid <= 1'h0;
    endtask
    task automatic op(input logic w, input logic [23:0] a, input logic [15:0] d);
        issue(w, a, d);
        wait_on(0);
        if (w) begin
            shadow[a[3:0]] = d;
        end else begin
            `CHK("read data", exp_rd(a), rdata)
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [23:0] a;
        void'($urandom(48));
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        repeat (8) @(posedge lclk);
        @(posedge clk);
        `CHK("grant idle", 1'h1, hg_n)
        // Every mode first, then random ones; zero and fifteen waits as corners.
        for (int i = 0; i < 40; i++) begin
            a = 24'($urandom);
            cfg(i < 5 ? i : int'($urandom % 5), i == 1 ? 4'hF : (i == 0 ? 4'h0 :
                4'($urandom % 4)), 4'($urandom % 4));
            op(1'h1, a, 16'($urandom));
            op(1'h0, a, 16'h0000);
            op(1'h0, 24'($urandom), 16'h0000);
        end
        // Hold arrives during a slow read; the read must finish first.
        arb <= 1'h1;
        need <= 1'h1;
        cfg(0, 4'h2, 4'h3);
        issue(1'h0, 24'h000005, 16'h0000);
        wait_on(1);
        hold_n <= 1'h0;
        wait_on(0);
        `CHK("read before grant", exp_rd(24'h000005), rdata)
        wait_on(2);
        repeat (8) @(posedge clk);
        `CHK("grant pin", 1'h0, hg_n)
        `CHK("strobe float", 1'h0, rd_oe)
        `CHK("addr float", 1'h0, a_oe)
        `CHK("latch low", 1'h0, ale)
        `CHK("data float", 1'h0, doe)
        `CHK("regain req", 1'h0, br_n)
        issue(1'h0, 24'h000007, 16'h0000);
        repeat (60) @(posedge clk);
        `CHK("held off", 1'h1, busy)
        hold_n <= 1'h1;
        wait_on(0);
        `CHK("regained read", exp_rd(24'h000007), rdata)
        `CHK("grant dropped", 1'h1, hg_n)
        `CHK("regain req off", 1'h1, br_n)
        // Hold withdrawn with no regain request from the device.
        need <= 1'h0;
        hold_n <= 1'h0;
        wait_on(2);
        repeat (8) @(posedge clk);
        `CHK("no regain req", 1'h1, br_n)
        hold_n <= 1'h1;
        wait_on(3);
        repeat (8) @(posedge clk);
        `CHK("redriven", 1'h1, rd_oe)
        // With arbitration off the hold request is ignored.
        arb <= 1'h0;
        repeat (12) @(posedge clk);
        hold_n <= 1'h0;
        op(1'h0, 24'h000005, 16'h0000);
        `CHK("no grant", 1'h1, hg_n)
        `CHK("still driven", 1'h1, a_oe)
        hold_n <= 1'h1;
        tally_and_finish();
    end
endmodule
